// [pio_ports.sv]
// parallel i/o ports a..g with pin sharing, stop modes and pin hold
// Notes on behaviour
// - unowned pins are gpio with four controls
// - data read: pin if dir 0, else latch
// - data writes update all latch bits except in hold or deep stop
// - drive latch only if unowned and output
// - owner sets direction, dir bit picks read
// - port g bit0 read returns pin level, never latch
// - pull only effective while dir bit 0
// - rising-edge keypad pins a4..a7 get pulldown instead
// - slew effective for outputs or peripheral outputs
// - serial units control their port e directions
// - async serial: e0 transmit, e1 receive
// - sync serial on e2..e5: ss, miso, mosi, sck
// - port f plain gpio, high-current drivers
// - debug and oscillator own port g pins
// - debug enable forces g0 pullup on
// - g0 mode-select in reset, debug after
// - deep stop resets registers, pins off
// - hold stop latches and holds pin state
// - held pins persist until ack written one
// - light stop retains everything
// - reset clears direction and pull bits
// - debug pin function enabled after reset
`timescale 1ns/1ps
module pio_ports #(
    parameter int NP = pio_pkg::NUM_PORTS,
    parameter int W = pio_pkg::PORT_W
) (
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // pins
    input wire logic [NP*W-1:0] pin_in,
    output logic [NP*W-1:0] pin_out,
    output logic [NP*W-1:0] pin_oe,
    output logic [NP*W-1:0] pin_pullup,
    output logic [NP*W-1:0] pin_pulldown,
    output logic [NP*W-1:0] pin_slew,
    // peripheral sharing
    input wire logic [W-1:0] keypad_en,
    input wire logic [W-1:0] keypad_rising,
    input wire logic async_serial1_en,
    input wire logic async_serial1_tx,
    output logic async_serial1_rx,
    input wire logic sync_serial_en,
    input wire logic sync_serial_master,
    input wire logic sync_serial_select_out,
    input wire logic sync_serial_master_out,
    input wire logic sync_serial_clock_out,
    input wire logic sync_serial_slave_out,
    output logic [3:0] sync_serial_pins_in,
    input wire logic osc_en,
    input wire logic osc_crystal_output_pin_out,
    input wire logic debug_out,
    input wire logic debug_oe,
    output logic debug_in,
    output logic debug_pin_function_enable,
    // stop control
    input wire logic [1:0] stop_state,
    output logic pins_held
);
    localparam int N = NP*W;

    ///////////////////////////////////////////////////////////////////////////
    // registers
    logic [N-1:0] port_data_latch;
    logic [N-1:0] port_direction_bits;
    logic [N-1:0] port_pull_enable;
    logic [N-1:0] port_slew_enable;
    logic [N-1:0] pin_sync;
    logic mode_select;
    logic [2:0] in_reset_q;
    pio_pkg::pio_hold_e hold_st;
    logic deep;
    logic pin_hold_release_ack;

    function automatic logic [2:0] port_of(input logic [5:0] a);
        port_of = a[2:0];
    endfunction : port_of

    function automatic logic hit(input logic [5:0] a, input logic [5:0] grp);
        hit = (a[5:3] == grp[5:3]) && (a[2:0] < 3'(NP));
    endfunction : hit

    assign deep = (stop_state == pio_pkg::STOP_DEEP);
    assign pin_hold_release_ack = wr && addr == pio_pkg::ADDR_CTRL
        && wdata[pio_pkg::CTRL_HOLD_ACK];

    pio_sync #(.W(N)) u_sync
    (
        .clk(clk),
        .arst_n(arst_n),
        .d(pin_in),
        .q(pin_sync)
    );

    // registers lose power in deep and hold stop: modelled as clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            {port_data_latch, port_direction_bits, port_pull_enable,
                port_slew_enable} <= '0;
        else if (deep || stop_state == pio_pkg::STOP_HOLD)
            {port_data_latch, port_direction_bits, port_pull_enable, port_slew_enable} <= '0;
        else if (wr)
        begin
            // light stop keeps all contents and still accepts writes
            if (hit(addr, pio_pkg::GRP_DATA))
                port_data_latch[port_of(addr)*W +: W] <= wdata;
            if (hit(addr, pio_pkg::GRP_DIR))
                port_direction_bits[port_of(addr)*W +: W] <= wdata;
            if (hit(addr, pio_pkg::GRP_PULL))
                port_pull_enable[port_of(addr)*W +: W] <= wdata;
            if (hit(addr, pio_pkg::GRP_SLEW))
                port_slew_enable[port_of(addr)*W +: W] <= wdata;
        end
    end

    // debug pin function enable: set by reset, cleared by software
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            debug_pin_function_enable <= pio_pkg::RST_CTRL[pio_pkg::CTRL_DBG_EN];
        else if (deep || stop_state == pio_pkg::STOP_HOLD)
            debug_pin_function_enable <= pio_pkg::RST_CTRL[pio_pkg::CTRL_DBG_EN];
        else if (wr && addr == pio_pkg::ADDR_CTRL)
            debug_pin_function_enable <= wdata[pio_pkg::CTRL_DBG_EN];
    end

    // g0 stays a mode-select input until the synchroniser holds a real pin level
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            in_reset_q <= '1;
            mode_select <= 1'b0;
        end
        else
        begin
            in_reset_q <= {in_reset_q[1:0], 1'b0};
            if (in_reset_q[2])
                mode_select <= pin_sync[pio_pkg::PORT_G*W];
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // pin hold state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            hold_st <= pio_pkg::HS_RUN;
        else
        begin
            case (hold_st)
                pio_pkg::HS_RUN:
                    if (stop_state == pio_pkg::STOP_HOLD)
                        hold_st <= pio_pkg::HS_HELD;
                pio_pkg::HS_HELD:
                    if (stop_state != pio_pkg::STOP_HOLD && pin_hold_release_ack)
                        hold_st <= pio_pkg::HS_RUN;
                default:
                    hold_st <= pio_pkg::HS_RUN;
            endcase
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // ownership and live pin controls
    logic [N-1:0] own;
    logic [N-1:0] own_oe;
    logic [N-1:0] own_out;
    logic [N-1:0] own_drives;
    logic [N-1:0] next_out;
    logic [N-1:0] next_oe;
    logic [N-1:0] next_pu;
    logic [N-1:0] next_pd;
    logic [N-1:0] next_slew;

    always_comb
    begin
        own = '0;
        own_oe = '0;
        own_out = '0;
        // keypad forces inputs on port a
        own[pio_pkg::PORT_A*W +: W] = keypad_en;
        // port e serial units
        if (async_serial1_en)
        begin
            own[pio_pkg::PORT_E*W + 0] = 1'b1;
            own_oe[pio_pkg::PORT_E*W + 0] = 1'b1;
            own_out[pio_pkg::PORT_E*W + 0] = async_serial1_tx;
            own[pio_pkg::PORT_E*W + 1] = 1'b1;
        end
        if (sync_serial_en)
        begin
            own[pio_pkg::PORT_E*W + 2 +: 4] = 4'hF;
            own_oe[pio_pkg::PORT_E*W + 2] = sync_serial_master;
            own_out[pio_pkg::PORT_E*W + 2] = sync_serial_select_out;
            own_oe[pio_pkg::PORT_E*W + 3] = !sync_serial_master;
            own_out[pio_pkg::PORT_E*W + 3] = sync_serial_slave_out;
            own_oe[pio_pkg::PORT_E*W + 4] = sync_serial_master;
            own_out[pio_pkg::PORT_E*W + 4] = sync_serial_master_out;
            own_oe[pio_pkg::PORT_E*W + 5] = sync_serial_master;
            own_out[pio_pkg::PORT_E*W + 5] = sync_serial_clock_out;
        end
        // port f never owned
        if (osc_en)
        begin
            own[pio_pkg::PORT_G*W + 1] = 1'b1;
            own_oe[pio_pkg::PORT_G*W + 1] = 1'b1;
            own_out[pio_pkg::PORT_G*W + 1] = osc_crystal_output_pin_out;
            own[pio_pkg::PORT_G*W + 2] = 1'b1;
        end
        if (debug_pin_function_enable || in_reset_q[2])
        begin
            own[pio_pkg::PORT_G*W] = 1'b1;
            own_oe[pio_pkg::PORT_G*W] = debug_oe && !in_reset_q[2];
            own_out[pio_pkg::PORT_G*W] = debug_out;
        end
    end

    assign own_drives = own & own_oe;

    always_comb
    begin
        next_out = (own & own_out) | (~own & port_data_latch);
        next_oe = own_drives | (~own & port_direction_bits);
        // pull only on input direction and not driven by owner
        next_pu = port_pull_enable & ~port_direction_bits & ~own_drives;
        next_pd = '0;
        for (int i = 4; i < 8; i++)
        begin
            if (keypad_en[i] && keypad_rising[i])
            begin
                next_pd[pio_pkg::PORT_A*W + i] = next_pu[pio_pkg::PORT_A*W + i];
                next_pu[pio_pkg::PORT_A*W + i] = 1'b0;
            end
        end
        if (debug_pin_function_enable)
            next_pu[pio_pkg::PORT_G*W] = 1'b1;
        next_slew = port_slew_enable & ((port_direction_bits & ~own) | own_drives);
    end

    // pin outputs; held state freezes them, deep stop forces reset state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            {pin_out, pin_oe, pin_pullup, pin_pulldown, pin_slew} <= '0;
        else if (deep)
            {pin_out, pin_oe, pin_pullup, pin_pulldown, pin_slew} <= '0;
        else if (hold_st == pio_pkg::HS_RUN && stop_state != pio_pkg::STOP_HOLD)
        begin
            // light stop takes this path unchanged
            pin_out <= next_out;
            pin_oe <= next_oe;
            pin_pullup <= next_pu;
            pin_pulldown <= next_pd;
            pin_slew <= next_slew;
        end
        // else held
    end

    assign pins_held = (hold_st == pio_pkg::HS_HELD);

    ///////////////////////////////////////////////////////////////////////////
    // peripheral inputs and register read
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            {async_serial1_rx, sync_serial_pins_in, debug_in} <= {1'b1, 4'h0, 1'b1};
        else
        begin
            async_serial1_rx <= pin_sync[pio_pkg::PORT_E*W + 1];
            sync_serial_pins_in <= pin_sync[pio_pkg::PORT_E*W + 2 +: 4];
            debug_in <= pin_sync[pio_pkg::PORT_G*W];
        end
    end

    logic [N-1:0] read_view;
    logic [7:0] next_rdata;

    always_comb
    begin
        read_view = (port_direction_bits & port_data_latch) | (~port_direction_bits & pin_sync);
        // g0 returns level on the pin itself
        read_view[pio_pkg::PORT_G*W] = pin_sync[pio_pkg::PORT_G*W];
        next_rdata = 8'h00;
        if (hit(addr, pio_pkg::GRP_DATA))
            next_rdata = read_view[port_of(addr)*W +: W];
        else if (hit(addr, pio_pkg::GRP_DIR))
            next_rdata = port_direction_bits[port_of(addr)*W +: W];
        else if (hit(addr, pio_pkg::GRP_PULL))
            next_rdata = port_pull_enable[port_of(addr)*W +: W];
        else if (hit(addr, pio_pkg::GRP_SLEW))
            next_rdata = port_slew_enable[port_of(addr)*W +: W];
        else if (addr == pio_pkg::ADDR_CTRL)
            next_rdata = {7'h00, debug_pin_function_enable};
        else if (addr == pio_pkg::ADDR_STAT)
            next_rdata = {6'h00, mode_select, pins_held};
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= 8'h00;
        else if (rd)
            rdata <= next_rdata;
        else
            rdata <= 8'h00;
    end

    ///////////////////////////////////////////////////////////////////////////
    // checks
    chk_dir_clear_reset: assert property (@(posedge clk)
        $rose(arst_n) |-> port_direction_bits == '0 && port_pull_enable == '0)
        else $error("direction or pull not cleared by reset");
    chk_write_latches: assert property (@(posedge clk) disable iff (!arst_n)
        wr && hit(addr, pio_pkg::GRP_DATA) && stop_state[1] == 1'b0
        |=> port_data_latch[port_of($past(addr))*W +: W] == $past(wdata))
        else $error("data write not latched");
    chk_deep_pins_off: assert property (@(posedge clk) disable iff (!arst_n)
        deep |=> pin_oe == '0 && pin_pullup == '0)
        else $error("pins not off in deep stop");
    chk_hold_freeze: assert property (@(posedge clk) disable iff (!arst_n)
        pins_held && !deep && !pin_hold_release_ack |=> $stable(pin_oe) && $stable(pin_out))
        else $error("held pins changed");
    chk_hold_release: assert property (@(posedge clk) disable iff (!arst_n)
        pins_held && stop_state != pio_pkg::STOP_HOLD && pin_hold_release_ack |=> !pins_held)
        else $error("hold not released by ack");
    chk_portf_gpio: assert property (@(posedge clk) disable iff (!arst_n)
        stop_state == pio_pkg::STOP_NONE && !pins_held
        |=> pin_oe[pio_pkg::PORT_F*W +: W] == $past(port_direction_bits[pio_pkg::PORT_F*W +: W]))
        else $error("port f not plain gpio");
    chk_g0_pullup: assert property (@(posedge clk) disable iff (!arst_n)
        debug_pin_function_enable && pins_held == 1'b0 && !deep
        && stop_state != pio_pkg::STOP_HOLD |=> pin_pullup[pio_pkg::PORT_G*W])
        else $error("debug pullup missing");
    chk_pull_input_only: assert property (@(posedge clk) disable iff (!arst_n)
        stop_state == pio_pkg::STOP_NONE && !pins_held |=> ((pin_pullup | pin_pulldown)
        & $past(port_direction_bits) & ~{{(W-1){1'b0}}, 1'b1, {(N-W){1'b0}}}) == '0)
        else $error("pull on output pin");
    chk_read_latch: assert property (@(posedge clk) disable iff (!arst_n)
        rd && hit(addr, pio_pkg::GRP_DATA) && port_of(addr) != 3'(pio_pkg::PORT_G) |=>
        ((rdata ^ $past(port_data_latch[port_of(addr)*W +: W]))
        & $past(port_direction_bits[port_of(addr)*W +: W])) == 8'h00)
        else $error("read did not return latch");
    chk_tx_pin: assert property (@(posedge clk) disable iff (!arst_n)
        async_serial1_en && !deep && !pins_held && stop_state != pio_pkg::STOP_HOLD
        |=> pin_oe[pio_pkg::PORT_E*W] && pin_out[pio_pkg::PORT_E*W] == $past(async_serial1_tx))
        else $error("transmit not on port e bit 0");

    cov_hold_cycle: cover property (@(posedge clk) disable iff (!arst_n) pins_held ##1 !pins_held);
    cov_deep: cover property (@(posedge clk) disable iff (!arst_n) deep);
    cov_spi: cover property (@(posedge clk) disable iff (!arst_n) sync_serial_en && rd);
    cov_keypad_pd: cover property (@(posedge clk) disable iff (!arst_n) |pin_pulldown);
endmodule : pio_ports

// [pio_pkg.sv]
// package of constants for the parallel i/o port block
package pio_pkg;
    localparam int NUM_PORTS = 7;
    localparam int PORT_W = 8;
    // port indices
    localparam int PORT_A = 0;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;
    // register groups, address = group*8 + port
    localparam logic [5:0] GRP_DATA = 6'h00;
    localparam logic [5:0] GRP_DIR = 6'h08;
    localparam logic [5:0] GRP_PULL = 6'h10;
    localparam logic [5:0] GRP_SLEW = 6'h18;
    localparam logic [5:0] ADDR_CTRL = 6'h20;
    localparam logic [5:0] ADDR_STAT = 6'h21;
    // ctrl bits
    localparam int CTRL_DBG_EN = 0;
    localparam int CTRL_HOLD_ACK = 1;
    // stat bits
    localparam int STAT_HOLD = 0;
    localparam int STAT_MODESEL = 1;
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h01;
    // stop states
    typedef enum logic [1:0]
    {
        STOP_NONE = 2'h0,
        STOP_LIGHT = 2'h1,
        STOP_HOLD = 2'h2,
        STOP_DEEP = 2'h3
    } pio_stop_e;
    // hold-state machine
    typedef enum logic [1:0]
    {
        HS_RUN = 2'b01,
        HS_HELD = 2'b10
    } pio_hold_e;
endpackage : pio_pkg

// [pio_sync.sv]
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module pio_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : pio_sync

// [pio_board.sv]
// board model resolving each port pin from all drivers and pulls
`timescale 1ns/1ps
module pio_board (
    input wire logic clk,
    input wire logic [55:0] pin_out,
    input wire logic [55:0] pin_oe,
    input wire logic [55:0] pin_pullup,
    input wire logic [55:0] pin_pulldown,
    input wire logic [55:0] ext_drv,
    input wire logic [55:0] ext_en,
    output logic [55:0] pin_in
);
    // floating pins toggle so a stale level never looks valid
    logic [55:0] flt = '0;
    always @(posedge clk)
    begin
        flt <= ~flt;
    end
    always_comb
    begin
        for (int i = 0; i < 56; i++)
        begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_drv[i];
            else if (pin_pullup[i])
                pin_in[i] = 1'b1;
            else if (pin_pulldown[i])
                pin_in[i] = 1'b0;
            else
                pin_in[i] = flt[i];
        end
    end
endmodule : pio_board

// [parallel_io_ports_bench.sv]
// self-checking bench for the parallel i/o ports
`timescale 1ns/1ps
module parallel_io_ports_bench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [55:0] pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown, pin_slew;
    // board straps g0 high so mode select reads as one
    logic [55:0] ext_drv = 56'h01_0000_0000_0000;
    logic [55:0] ext_en = 56'h01_0000_0000_0000;
    logic [7:0] kp_en = 8'h00;
    logic [7:0] kp_rise = 8'h00;
    logic as_en = 1'b0, as_tx = 1'b0, as_rx;
    logic ss_en = 1'b0, ss_m = 1'b0, ss_o = 1'b0;
    logic [3:0] ss_in;
    logic osc_en = 1'b0, osc_x = 1'b0;
    logic dbg_out = 1'b0, dbg_oe = 1'b0, dbg_in, dbg_fe;
    logic [1:0] stop_state = 2'h0;
    logic pins_held;
    logic [7:0] d;
    int error_cnt = 0;
    int checked = 0;

    always #2.5 clk = ~clk;

    pio_ports i_pio_ports (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown), .pin_slew(pin_slew),
        .keypad_en(kp_en), .keypad_rising(kp_rise), .async_serial1_en(as_en),
        .async_serial1_tx(as_tx), .async_serial1_rx(as_rx), .sync_serial_en(ss_en),
        .sync_serial_master(ss_m), .sync_serial_select_out(ss_o),
        .sync_serial_master_out(ss_o), .sync_serial_clock_out(ss_o),
        .sync_serial_slave_out(ss_o), .sync_serial_pins_in(ss_in), .osc_en(osc_en),
        .osc_crystal_output_pin_out(osc_x), .debug_out(dbg_out), .debug_oe(dbg_oe), .debug_in(dbg_in),
        .debug_pin_function_enable(dbg_fe), .stop_state(stop_state), .pins_held(pins_held));

    pio_board i_pio_board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown), .ext_drv(ext_drv),
        .ext_en(ext_en), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    task wreg(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task rreg(input logic [5:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rreg

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task print_verdict;
        $display("compares %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        // mode select keeps sampling g0 until the synchroniser has filled
        tick(3);
        rreg(pio_pkg::ADDR_STAT, d);
        chk(d & 8'h02, 8'h02);
        ext_en <= 56'h0000_0000_0000_00;
        rreg(pio_pkg::GRP_DIR, d);
        chk(d, 8'h00);
        rreg(pio_pkg::GRP_PULL | 6'h02, d);
        chk(d, 8'h00);
        chk(pin_oe[7:0], 8'h00);
        chk({7'h00, dbg_fe}, 8'h01);
        chk({7'h00, pin_pullup[48]}, 8'h01);
    endtask : t_reset

    task t_gpio;
        ext_en[40 +: 8] <= 8'hf0;
        ext_drv[40 +: 8] <= 8'h3c;
        wreg(pio_pkg::GRP_DATA | 6'h05, 8'ha5);
        wreg(pio_pkg::GRP_DIR | 6'h05, 8'h0f);
        tick(2);
        chk(pin_oe[40 +: 8], 8'h0f);
        chk(pin_out[40 +: 8] & 8'h0f, 8'h05);
        rreg(pio_pkg::GRP_DATA | 6'h05, d);
        chk(d, 8'h35);
        // input pins still on the outer drive, dir bits to latch
        wreg(pio_pkg::GRP_DATA | 6'h01, 8'h5a);
        tick(2);
        chk(pin_oe[8 +: 8], 8'h00);
        wreg(pio_pkg::GRP_DIR | 6'h01, 8'hff);
        tick(2);
        chk(pin_out[8 +: 8], 8'h5a);
    endtask : t_gpio

    task t_pull;
        wreg(pio_pkg::GRP_PULL | 6'h02, 8'hff);
        wreg(pio_pkg::GRP_DIR | 6'h02, 8'hf0);
        wreg(pio_pkg::GRP_SLEW | 6'h02, 8'hff);
        tick(2);
        chk(pin_pullup[16 +: 8], 8'h0f);
        chk(pin_slew[16 +: 8], 8'hf0);
        kp_en <= 8'hf0;
        kp_rise <= 8'hc0;
        wreg(pio_pkg::GRP_PULL, 8'hff);
        tick(2);
        chk(pin_pulldown[7:0], 8'hc0);
        chk(pin_pullup[7:0], 8'h3f);
        wreg(pio_pkg::GRP_DIR, 8'hf0);
        tick(2);
        chk(pin_oe[7:0], 8'h00);
        kp_en <= 8'h00;
    endtask : t_pull

    task t_serial;
        as_en <= 1'b1;
        as_tx <= 1'b1;
        ext_en[33] <= 1'b1;
        ext_drv[33] <= 1'b0;
        tick(4);
        chk({6'h00, pin_oe[33:32]}, 8'h01);
        chk({7'h00, pin_out[32]}, 8'h01);
        chk({7'h00, as_rx}, 8'h00);
        wreg(pio_pkg::GRP_DIR | 6'h04, 8'h01);
        rreg(pio_pkg::GRP_DATA | 6'h04, d);
        chk(d & 8'h01, 8'h00);
        ss_en <= 1'b1;
        ss_m <= 1'b1;
        ss_o <= 1'b1;
        ext_en[35] <= 1'b1;
        ext_drv[35] <= 1'b1;
        tick(4);
        chk({4'h0, pin_oe[37:34]}, 8'h0d);
        chk({4'h0, pin_out[37:34] & 4'hd}, 8'h0d);
        chk({7'h00, ss_in[1]}, 8'h01);
        ss_m <= 1'b0;
        tick(3);
        chk({4'h0, pin_oe[37:34] & pin_out[37:34]}, 8'h02);
        as_en <= 1'b0;
        ss_en <= 1'b0;
    endtask : t_serial

    task t_portg;
        // debug drives low against the forced pullup and a latch of one
        dbg_oe <= 1'b1;
        dbg_out <= 1'b0;
        wreg(pio_pkg::GRP_DATA | 6'h06, 8'h01);
        wreg(pio_pkg::GRP_DIR | 6'h06, 8'h01);
        tick(4);
        chk({7'h00, pin_oe[48] & ~pin_out[48]}, 8'h01);
        chk({7'h00, dbg_in}, 8'h00);
        rreg(pio_pkg::GRP_DATA | 6'h06, d);
        chk(d & 8'h01, 8'h00);
        wreg(pio_pkg::ADDR_CTRL, 8'h00);
        dbg_oe <= 1'b0;
        tick(2);
        chk({7'h00, pin_oe[48] & pin_out[48]}, 8'h01);
        chk({7'h00, pin_pullup[48]}, 8'h00);
        osc_en <= 1'b1;
        osc_x <= 1'b1;
        tick(3);
        chk({6'h00, pin_oe[50:49]}, 8'h01);
        chk({7'h00, pin_out[49]}, 8'h01);
    endtask : t_portg

    task t_stop;
        stop_state <= pio_pkg::STOP_LIGHT;
        tick(3);
        chk(pin_oe[40 +: 8], 8'h0f);
        stop_state <= pio_pkg::STOP_NONE;
        rreg(pio_pkg::GRP_DIR | 6'h05, d);
        chk(d, 8'h0f);
        stop_state <= pio_pkg::STOP_HOLD;
        tick(3);
        chk({7'h00, pins_held}, 8'h01);
        chk(pin_out[40 +: 8] & pin_oe[40 +: 8], 8'h05);
        stop_state <= pio_pkg::STOP_NONE;
        rreg(pio_pkg::GRP_DIR | 6'h05, d);
        chk(d, 8'h00);
        chk(pin_oe[40 +: 8], 8'h0f);
        // restore before release so the pins do not glitch
        wreg(pio_pkg::GRP_DATA | 6'h05, 8'ha5);
        wreg(pio_pkg::GRP_DIR | 6'h05, 8'h0f);
        tick(2);
        chk({7'h00, pins_held}, 8'h01);
        wreg(pio_pkg::ADDR_CTRL, 8'h02);
        tick(1);
        chk({7'h00, pins_held}, 8'h00);
        stop_state <= pio_pkg::STOP_DEEP;
        tick(3);
        chk({7'h00, |pin_oe}, 8'h00);
        chk({7'h00, |{pin_pullup, pin_pulldown}}, 8'h00);
        stop_state <= pio_pkg::STOP_NONE;
        rreg(pio_pkg::GRP_DIR | 6'h05, d);
        chk(d, 8'h00);
        wreg(pio_pkg::GRP_DIR | 6'h05, 8'h0f);
        tick(2);
        chk(pin_oe[40 +: 8], 8'h0f);
    endtask : t_stop

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_gpio();
        t_pull();
        t_serial();
        t_portg();
        t_stop();
        print_verdict();
    end

    // whole run is well under a thousand cycles
    initial
    begin
        #50000;
        error_cnt++;
        print_verdict();
    end
endmodule : parallel_io_ports_bench
